// File: rtl/gtm_consts.svh
// constants of the gated 16-bit timer
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH
`define GTM_CS_INSTR      2'h0
`define GTM_CS_SYSCLK     2'h1
`define GTM_CS_EXT        2'h2
`define GTM_CS_LFOSC      2'h3
`define GTM_GS_PIN        2'h0
`define GTM_GS_T0OVF      2'h1
`define GTM_GS_CMP1       2'h2
`define GTM_GS_CMP2       2'h3
`define GTM_INSTR_DIV     2'h3
`define GTM_COUNT_RST     16'h0000
`define GTM_COUNT_MAX     16'hFFFF
`define GTM_T0_MAX        8'hFF
`endif

// File: rtl/gtm_edge_arm.sv
// falling-before-rising edge qualifier for the external counter input
`default_nettype none
module gtm_edge_arm
    import gtm_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic rearm,
    input  wire logic src_level,
    output logic      rise_pulse
);
    gtm_edge_state_t state_q;
    logic            prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= src_level;
        end
    end

    // after rearm a rising edge counts only once a low level was seen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GTM_EDGE_WAIT_LOW;
        end else if (rearm) begin
            state_q <= GTM_EDGE_WAIT_LOW; // [R7]
        end else begin
            case (state_q)
                GTM_EDGE_WAIT_LOW: if (!src_level) state_q <= GTM_EDGE_ARMED; // [R7]
                default: state_q <= GTM_EDGE_ARMED;
            endcase
        end
    end

    assign rise_pulse = (state_q == GTM_EDGE_ARMED) && !rearm && src_level && !prev_q;
endmodule
`default_nettype wire

// File: rtl/gtm_pkg.sv
// types of the gated 16-bit timer
`default_nettype none
package gtm_pkg;
    typedef enum logic [1:0] {
        GTM_EDGE_ARMED = 2'b00,
        GTM_EDGE_WAIT_LOW = 2'b01
    } gtm_edge_state_t;
endpackage
`default_nettype wire

// File: rtl/gtm_sync2.sv
// two-flop level synchroniser
`default_nettype none
module gtm_sync2 (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: rtl/gtm_timer.sv
// gated 16-bit timer/counter top
//
// Function
// [R1] 16-bit counter, byte writes load directly
// [R2] run enable off; gate enable gates counting
// [R3] clock select picks instr, sys, pin, lfosc
// [R4] instr clock: one count per instruction
// [R5] system clock: four counts per instruction
// [R6] pin source counts rising edges, sync optional
// [R7] falling edge required before first rising
// [R8] prescale 1,2,4,8, hidden from software
// [R9] counter byte write clears prescaler
// [R10] oscillator enable runs crystal, also in sleep
// [R11] software waits FC00h preset for stability
// [R12] sync disable: async counting, runs in sleep; the code still edge-detects the raw level and counts on core_clk
// [R13] sync mode switch may skip or add one
// [R14] byte reads always return a valid byte
// [R15] software stops counter before async writes
// [R16] gate open counts, gate closed holds
// [R17] gate polarity selects active gate level
// [R18] gate source pin, t0 overflow, comparators
// [R19] rollover sets sticky overflow flag
// [R20] t0 overflow makes a gate pulse
// [R21] reset clears counter, prescaler, controls
`include "gtm_consts.svh"
`default_nettype none
module gtm_timer (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       run_enable,
    input  wire logic       gate_enable,
    input  wire logic [1:0] clock_select,
    input  wire logic       secondary_osc_enable,
    input  wire logic [1:0] prescale_select,
    input  wire logic       sync_disable,
    input  wire logic       gate_polarity,
    input  wire logic [1:0] gate_source_select,
    input  wire logic       comparator_sync_enable,
    input  wire logic       external_clock_in,
    input  wire logic       crystal_in_pin,
    input  wire logic       low_freq_internal_osc,
    input  wire logic       gate_pin,
    input  wire logic       comparator_one_out,
    input  wire logic       comparator_two_out,
    input  wire logic [7:0] eight_bit_timer_count,
    input  wire logic       high_write,
    input  wire logic       low_write,
    input  wire logic [7:0] write_data,
    input  wire logic       flag_clear,
    output logic [7:0]      count_high_byte,
    output logic [7:0]      count_low_byte,
    output logic            overflow_flag,
    output logic            crystal_out_pin,
    output logic            osc_running
);
    import gtm_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic prescale_done(input logic [2:0] cnt, input logic [1:0] sel);
        logic [2:0] lim;
        lim = 3'((4'h1 << sel) - 4'h1);
        prescale_done = (cnt == lim);
    endfunction

    // ------------------------------------------------------------
    // instruction clock enable: system clock divided by four
    // ------------------------------------------------------------
    logic [1:0] instr_div_q;
    logic       instr_tick;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_div_q <= 2'h0;
        end else begin
            instr_div_q <= 2'(instr_div_q + 2'h1);
        end
    end

    assign instr_tick = (instr_div_q == `GTM_INSTR_DIV); // [R4]

    // ------------------------------------------------------------
    // external sources: pin or crystal, optional synchroniser
    // ------------------------------------------------------------
    // crystal amplifier: inverted input drives back out while enabled; oscillator has no sleep gating
    assign crystal_out_pin = secondary_osc_enable ? ~crystal_in_pin : 1'b0; // [R10]
    assign osc_running     = secondary_osc_enable; // [R10]

    logic ext_raw;
    logic ext_sync;
    logic ext_level;
    logic lf_sync;

    assign ext_raw = secondary_osc_enable ? crystal_in_pin : external_clock_in;

    gtm_sync2 u_ext_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (ext_raw),
        .q        (ext_sync)
    );

    gtm_sync2 u_lf_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (low_freq_internal_osc),
        .q        (lf_sync)
    );

    // with sync disabled the raw level is sampled directly: two clocks less latency, so a mode
    // change may drop or duplicate a single edge
    assign ext_level = sync_disable ? ext_raw : ext_sync; // [R6] [R12] [R13]

    // ------------------------------------------------------------
    // edge qualification for counter mode
    // ------------------------------------------------------------
    logic run_q;
    logic rearm;
    logic ext_rise;
    logic lf_rise;
    logic byte_write;

    assign byte_write = high_write | low_write;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_enable;
        end
    end

    assign rearm = byte_write | !run_enable; // [R7]

    gtm_edge_arm u_ext_edge (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .rearm      (rearm),
        .src_level  (ext_level),
        .rise_pulse (ext_rise)
    );

    gtm_edge_arm u_lf_edge (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .rearm      (!run_q && !run_enable),
        .src_level  (lf_sync),
        .rise_pulse (lf_rise)
    );

    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    logic src_tick;
    logic [2:0] src_step;

    always_comb begin
        src_tick = 1'b0;
        src_step = 3'h1;
        case (clock_select)
            `GTM_CS_LFOSC:  src_tick = lf_rise; // [R3]
            `GTM_CS_EXT:    src_tick = ext_rise; // [R3] [R6]
            `GTM_CS_SYSCLK: src_tick = 1'b1; // [R3] [R5]
            default:        src_tick = instr_tick; // [R3] [R4]
        endcase
    end

    // ------------------------------------------------------------
    // gate
    // ------------------------------------------------------------
    logic [7:0] t0_prev_q;
    logic       t0_pulse_q;
    logic       cmp1_sync;
    logic       cmp2_sync;
    logic       gate_src;
    logic       gate_open;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            t0_prev_q  <= 8'h00;
            t0_pulse_q <= 1'b0;
        end else begin
            t0_prev_q  <= eight_bit_timer_count;
            t0_pulse_q <= (t0_prev_q == `GTM_T0_MAX) && (eight_bit_timer_count == 8'h00); // [R20]
        end
    end

    gtm_sync2 u_cmp1_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (comparator_one_out),
        .q        (cmp1_sync)
    );

    gtm_sync2 u_cmp2_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (comparator_two_out),
        .q        (cmp2_sync)
    );

    always_comb begin
        gate_src = gate_pin;
        if (gate_source_select == `GTM_GS_PIN) begin
            gate_src = gate_pin; // [R18]
        end else if (gate_source_select == `GTM_GS_T0OVF) begin
            gate_src = t0_pulse_q; // [R18] [R20]
        end else if (gate_source_select == `GTM_GS_CMP1) begin
            gate_src = comparator_sync_enable ? cmp1_sync : comparator_one_out; // [R18]
        end else begin
            gate_src = comparator_sync_enable ? cmp2_sync : comparator_two_out; // [R18]
        end
    end

    // polarity 0 counts on low, 1 counts on high
    assign gate_open = (gate_src == gate_polarity); // [R17]

    logic count_en;
    assign count_en = run_enable && (!gate_enable || gate_open); // [R2] [R16]

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [2:0] pre_q;
    logic       pre_tick;

    assign pre_tick = count_en && src_tick && prescale_done(pre_q, prescale_select); // [R8]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 3'h0; // [R21]
        end else if (byte_write) begin
            pre_q <= 3'h0; // [R9]
        end else if (count_en && src_tick) begin
            pre_q <= pre_tick ? 3'h0 : 3'(pre_q + 3'h1); // [R8]
        end
    end

    // ------------------------------------------------------------
    // counter and overflow
    // ------------------------------------------------------------
    logic [15:0] count_q;
    logic        rollover;

    assign rollover = pre_tick && !byte_write && (count_q == `GTM_COUNT_MAX);

    // a byte write wins over a coincident increment
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `GTM_COUNT_RST; // [R21]
        end else if (high_write) begin
            count_q <= {write_data, count_q[7:0]}; // [R1]
        end else if (low_write) begin
            count_q <= {count_q[15:8], write_data}; // [R1]
        end else if (pre_tick) begin
            count_q <= 16'(count_q + 16'h0001); // [R1]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (rollover) begin
            overflow_flag <= 1'b1; // [R19]
        end else if (flag_clear) begin
            overflow_flag <= 1'b0;
        end
    end

    // registered count: every read returns a settled byte
    assign count_high_byte = count_q[15:8]; // [R14]
    assign count_low_byte  = count_q[7:0]; // [R14]

    logic unused_step;
    assign unused_step = ^src_step;
endmodule
`default_nettype wire

// File: tb/gtm_src_model.sv
// far-side sources: clock pin, watch crystal, slow oscillator
`default_nettype none
module gtm_src_model (
    input  wire logic ext_go,
    output logic      ext_clk,
    output logic      xtal,
    output logic      lf_osc
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ext_clk = 1'b1;
        xtal = 1'b0;
        lf_osc = 1'b0;
    end
    // pin parks high between bursts, so enabling never sees a fresh rise
    always begin
        #20;
        if (ext_go || !ext_clk) begin
            ext_clk = !ext_clk;
        end
    end
    always #30 xtal = !xtal;
    always #50 lf_osc = !lf_osc;
endmodule
`default_nettype wire

// File: tb/gtm_timer_properties.sv
// concurrent checks on the gated timer ports
`include "gtm_consts.svh"
`default_nettype none
module gtm_timer_props (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       run_enable,
    input wire logic       high_write,
    input wire logic       low_write,
    input wire logic [7:0] write_data,
    input wire logic       flag_clear,
    input wire logic [7:0] count_high_byte,
    input wire logic [7:0] count_low_byte,
    input wire logic       overflow_flag,
    input wire logic       crystal_in_pin,
    input wire logic       secondary_osc_enable,
    input wire logic       crystal_out_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    wire logic [15:0] cnt = {count_high_byte, count_low_byte};
    wire logic        wr_any = high_write || low_write;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    off_holds_a: assert property (!run_enable && $past(!run_enable) && $past(!run_enable, 2) &&
        !$past(wr_any) |-> $stable(cnt)) else $error("count moved while off");
    low_load_a: assert property (low_write && !high_write |=> count_low_byte == $past(write_data))
        else $error("low byte not loaded");
    high_load_a: assert property (high_write |=> count_high_byte == $past(write_data))
        else $error("high byte not loaded");
    wrap_flag_a: assert property ($past(cnt) == `GTM_COUNT_MAX && cnt == `GTM_COUNT_RST &&
        !$past(wr_any) |-> ##[0:1] overflow_flag) else $error("rollover left flag clear");
    flag_sticky_a: assert property (overflow_flag && !flag_clear |=> overflow_flag)
        else $error("flag dropped alone");
    flag_clear_a: assert property (flag_clear && cnt != `GTM_COUNT_MAX && cnt != `GTM_COUNT_RST
        |=> !overflow_flag) else $error("flag not cleared");
    step_one_a: assert property ($past(run_enable) && !$past(wr_any) |->
        cnt == $past(cnt) || cnt == $past(cnt) + 16'h0001) else $error("count jumped");
    xtal_drive_a: assert property (crystal_out_pin == (secondary_osc_enable && !crystal_in_pin))
        else $error("crystal drive wrong");
endmodule
bind gtm_timer gtm_timer_props gtm_timer_props_i (.*);
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the gated timer
`include "gtm_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------
    logic       core_clk, nrst, run_enable, gate_enable, secondary_osc_enable, sync_disable;
    logic       gate_polarity, comparator_sync_enable, gate_pin, comparator_one_out;
    logic       comparator_two_out, high_write, low_write, flag_clear, ext_go;
    logic [1:0] clock_select, prescale_select, gate_source_select;
    logic [7:0] eight_bit_timer_count, write_data, count_high_byte, count_low_byte;
    logic       overflow_flag, crystal_out_pin, osc_running;
    wire logic  external_clock_in, crystal_in_pin, low_freq_internal_osc;
    int         bad_count, comparisons, rises;
    wire logic [15:0] cnt = {count_high_byte, count_low_byte};
    gtm_timer gtm_timer_i (.*);
    gtm_src_model gtm_src_model_i (.ext_go(ext_go), .ext_clk(external_clock_in), .xtal(crystal_in_pin),
        .lf_osc(low_freq_internal_osc));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge external_clock_in) if (run_enable) rises++;
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input int tol);
        comparisons++;
        if (^got === 1'bx || int'(got) + tol < int'(exp) || int'(got) > int'(exp) + tol) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic hi, input logic [7:0] d);
        high_write = hi;
        low_write = !hi;
        write_data = d;
        @(negedge core_clk);
        high_write = 1'b0;
        low_write = 1'b0;
        @(negedge core_clk);
    endtask
    // stop first: a write racing an increment wins and that increment is lost
    task automatic load(input logic [15:0] v);
        run_enable = 1'b0;
        repeat (4) @(negedge core_clk);
        wr(1'b1, v[15:8]);
        wr(1'b0, v[7:0]);
    endtask
    task automatic run_for(input int n);
        run_enable = 1'b1;
        repeat (n) @(negedge core_clk);
        run_enable = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask
    initial begin
        #100us;
        bad_count++;
        close_out();
    end
    initial begin
        {nrst, run_enable, gate_enable, secondary_osc_enable, sync_disable, gate_polarity, gate_pin,
         comparator_sync_enable, comparator_one_out, comparator_two_out, high_write, low_write,
         flag_clear, ext_go} = '0;
        {clock_select, prescale_select, gate_source_select, eight_bit_timer_count, write_data} = '0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        repeat (3) @(negedge core_clk);
        check(cnt, 16'h0000, 0);
        check(16'(overflow_flag), 16'h0000, 0);
        load(16'hFFFE);
        check(cnt, 16'hFFFE, 0);
        clock_select = `GTM_CS_SYSCLK;
        run_for(8);
        check(cnt, 16'h0006, 1);
        check(16'(overflow_flag), 16'h0001, 0);
        flag_clear = 1'b1;
        @(negedge core_clk);
        flag_clear = 1'b0;
        @(negedge core_clk);
        check(16'(overflow_flag), 16'h0000, 0);
        for (int p = 0; p < 4; p++) begin
            prescale_select = 2'(p);
            load(16'h0000);
            run_for(64);
            check(cnt, 16'(64 >> p), 1);
        end
        prescale_select = 2'h0;
        clock_select = `GTM_CS_INSTR;
        load(16'h0000);
        run_for(64);
        check(cnt, 16'h0010, 1);
        clock_select = `GTM_CS_LFOSC;
        load(16'h0000);
        run_for(400);
        check(cnt, 16'h0014, 1);
        clock_select = `GTM_CS_SYSCLK;
        gate_enable = 1'b1;
        for (int k = 0; k < 16; k++) begin
            if (k[3:2] == 2'h1) continue;
            gate_source_select = k[3:2];
            gate_polarity = k[1];
            comparator_sync_enable = k[2];
            gate_pin = (k[3:2] == `GTM_GS_PIN) ? k[0] : !k[0];
            comparator_one_out = (k[3:2] == `GTM_GS_CMP1) ? k[0] : !k[0];
            comparator_two_out = (k[3:2] == `GTM_GS_CMP2) ? k[0] : !k[0];
            load(16'h0000);
            run_for(32);
            check(cnt, (k[0] == k[1]) ? 16'h0020 : 16'h0000, 2);
        end
        gate_source_select = `GTM_GS_T0OVF;
        gate_polarity = 1'b1;
        eight_bit_timer_count = `GTM_T0_MAX;
        load(16'h0000);
        run_enable = 1'b1;
        repeat (4) @(negedge core_clk);
        eight_bit_timer_count = 8'h00;
        run_for(8);
        check(cnt, 16'h0001, 1);
        gate_enable = 1'b0;
        clock_select = `GTM_CS_EXT;
        for (int sd = 0; sd < 2; sd++) begin
            sync_disable = sd[0];
            load(16'h0000);
            run_enable = 1'b1;
            repeat (8) @(negedge core_clk);
            check(cnt, 16'h0000, 0);
            rises = 0;
            ext_go = 1'b1;
            repeat (100) @(negedge core_clk);
            ext_go = 1'b0;
            run_for(16);
            check(cnt, 16'(rises), 0);
        end
        sync_disable = 1'b0;
        secondary_osc_enable = 1'b1;
        load(16'h0000);
        run_for(300);
        check(cnt, 16'h0019, 1);
        check(16'(osc_running), 16'h0001, 0);
        // stability wait: clear flag, preset, flag rises after 1024 ticks
        clock_select = `GTM_CS_SYSCLK;
        flag_clear = 1'b1;
        @(negedge core_clk);
        flag_clear = 1'b0;
        load(16'hFC00);
        run_for(1023);
        check(16'(overflow_flag), 16'h0000, 0);
        run_for(1);
        check(16'(overflow_flag), 16'h0001, 0);
        check(cnt, 16'h0000, 0);
        close_out();
    end
endmodule
`default_nettype wire
